// ===== spc_master_model.sv
`timescale 1ns/100ps
module spc_master_model (
	// Clock
	input wire logic core_clk,
	// Line
	input wire logic line_oe,
	output logic line_in
);
	logic pull = 1'b0;
	logic last_level = 1'b1;
	int cyc = 0;
	int falls[$];
	// Pull-up: line is low whenever any party pulls
	assign line_in = !(pull || line_oe);
	always @(posedge core_clk) begin
		cyc <= cyc + 1;
		last_level <= line_in;
		if (last_level && !line_in) begin
			falls.push_back(cyc);
		end
	end
	task automatic trigger(input int blank_cyc, input int low_cyc);
		repeat (blank_cyc) @(posedge core_clk);
		pull <= 1'b1;
		repeat (low_cyc) @(posedge core_clk);
		pull <= 1'b0;
	endtask
endmodule

// ===== spc_pkg.sv
package spc_pkg;
	// ==================== Timing ====================
	localparam int SPC_CLK_NS = 4;
	localparam int SPC_UT_MIN_NS = 1500;
	localparam int SPC_UT_STEP_NS = 500;
	localparam int SPC_SYNC_UT = 56;
	localparam int SPC_END_UT = 12;
	localparam int SPC_NIB_BASE_UT = 12;
	localparam int SPC_LOW_SHORT_UT = 3;
	localparam int SPC_LOW_LONG_UT = 5;
	localparam int SPC_TRIG_CONST_UT = 90;
	localparam int SPC_TRIG_VAR_ADD_UT = 12;
	// Address windows of the trigger low time, in half unit times
	localparam logic [3:0][7:0] SPC_WIN_LO = {8'h7B, 8'h47, 8'h26, 8'h12};
	localparam logic [3:0][7:0] SPC_WIN_HI = {8'h87, 8'h51, 8'h2E, 8'h18};
	localparam logic [7:0] SPC_WIN_MAX = 8'h87;

	// ==================== Checksum ====================
	localparam logic [3:0] SPC_CRC_POLY = 4'hD;
	localparam logic [3:0] SPC_CRC_SEED = 4'h5;

	// ==================== Register map ====================
	localparam logic [2:0] SPC_REG_CTRL = 3'h0;
	localparam logic [2:0] SPC_REG_ANGLE = 3'h1;
	localparam logic [2:0] SPC_REG_FAULT = 3'h2;
	localparam logic [2:0] SPC_REG_TEMP = 3'h3;
	localparam logic [2:0] SPC_REG_BASE = 3'h4;
	localparam logic [2:0] SPC_REG_ID1 = 3'h5;
	localparam logic [2:0] SPC_REG_ID2 = 3'h6;
	localparam logic [2:0] SPC_REG_STATUS = 3'h7;
	// Control fields
	localparam int SPC_C_EN = 0;
	localparam int SPC_C_VARTRIG = 1;
	localparam int SPC_C_LOW5 = 2;
	localparam int SPC_C_CTR_NIB = 3;
	localparam int SPC_C_CTR_CRC = 4;
	localparam int SPC_C_SLOW = 5;
	localparam int SPC_C_ADDR = 6;
	localparam int SPC_C_UT = 8;
	localparam logic [9:0] SPC_CTRL_RST = 10'h008;
	// Fault fields
	localparam int SPC_F_WARN = 0;
	localparam int SPC_F_ERR = 1;
	// Segment indices of a frame
	localparam logic [2:0] SPC_SEG_SYNC = 3'h0;
	localparam logic [2:0] SPC_SEG_D3 = 3'h4;
	localparam logic [2:0] SPC_SEG_CTR = 3'h5;
	localparam logic [2:0] SPC_SEG_CRC = 3'h6;
	localparam logic [2:0] SPC_SEG_END = 3'h7;

	typedef enum logic [3:0] {
		SPC_IDLE = 4'b0001,
		SPC_TRIG_LOW = 4'b0010,
		SPC_TRIG_WAIT = 4'b0100,
		SPC_SEND = 4'b1000
	} spc_state_t;
endpackage

// ===== spc_triggered_frame_transmitter.sv
// Function
// - Constant trigger length: whole trigger nibble spans 90 unit times.
// - Variable trigger length: total trigger time is upper end of matched address window plus 12 UT.
// - Trigger timed by fixed unit-time counts; drifts only with the clock.
// - Different address next: blanking at most 50 us after end pulse rise.
// - Nibble low portion lasts 3 or 5 UT by configuration.
// - 4-bit frame counter increments per frame and wraps to zero.
// - Counter nibble sits after third data nibble, before checksum.
// - Counter nibble can be removed by configuration.
// - Counter may be folded into checksum using two low bits only.
// - Slow channel: status bit 1 is 1 in first of 16 frames.
// - Slow message: 16 bits in status bit 0, MSB first, id/data/crc.
// - Ids 0,3 temperature; 1,2 angle base; 4-7 two id words; 8-15 repeat.
// - Slow channel on: address leaves status bits, goes into checksum.
// - Temperature is 8-bit two's complement.
// - Checksum: CRC x^4+x^3+x^2+1, seed 0101, over status and data.
// - Slow off, counter nibble: input status, data, counter.
// - Counter folded, slow off: extra nibble counter low bits, 00.
// - Slow on, counter nibble: extra nibble 00 then address.
// - Slow on, counter folded: extra nibble counter low bits, address.
// - Frame: 56 UT sync, status, three data, counter, checksum, 12 UT end.
// - Nibble value is falling-edge spacing of 12 to 27 UT.
// - Trigger low time picks address among four windows.
// - Status bit 2 warning, bit 3 error, held while present, shown once.
`timescale 1ns/100ps
module spc_triggered_frame_transmitter (
	// Clock and reset
	input wire logic core_clk,
	input wire logic rst,
	// Avalon-MM slave
	input wire logic [4:0] avs_address,
	input wire logic avs_read,
	input wire logic avs_write,
	input wire logic [31:0] avs_writedata,
	input wire logic [3:0] avs_byteenable,
	output logic [31:0] avs_readdata,
	output logic avs_waitrequest,
	// Open-drain output line
	input wire logic line_in,
	output logic line_out,
	output logic line_oe
);
	import spc_pkg::*;

	// ==================== State ====================
	typedef struct packed {
		spc_state_t st;
		logic [1:0] sync;
		logic line_q;
		logic [8:0] half_cnt;
		logic [7:0] tcnt;
		logic [1:0] addr_hit;
		logic [2:0] seg;
		logic [6:0] seg_t;
		logic [5:0][3:0] nib;
		logic drive;
		logic [3:0] frame_ctr;
		logic [3:0] slow_idx;
		logic [3:0] slow_id;
		logic [15:0] slow_word;
		logic warn_pend;
		logic err_pend;
		logic ack;
		logic [31:0] rdata;
		logic [9:0] ctrl;
		logic [11:0] angle;
		logic [1:0] fault;
		logic [7:0] temp;
		logic [15:0] base;
		logic [15:0] id1;
		logic [15:0] id2;
	} spc_regs_t;

	spc_regs_t r;
	spc_regs_t next_r;

	// ==================== Functions ====================
	function automatic logic [3:0] spc_crc_step(input logic [3:0] crc, input logic [3:0] nib);
		logic [3:0] c;
		logic fb;
		c = crc;
		for (int i = 3; i >= 0; i--) begin
			fb = c[3] ^ nib[i];
			c = {c[2:0], 1'b0};
			if (fb) begin
				c = c ^ SPC_CRC_POLY;
			end
		end
		return c;
	endfunction

	function automatic logic [31:0] spc_merge(input logic [31:0] old, input logic [31:0] wd,
			input logic [3:0] be);
		logic [31:0] m;
		m = old;
		for (int b = 0; b < 4; b++) begin
			if (be[b]) begin
				m[b*8 +: 8] = wd[b*8 +: 8];
			end
		end
		return m;
	endfunction

	// ==================== Combinational ====================
	logic [8:0] half_cyc;
	logic tick;
	logic line_s;
	logic fall;
	logic rise;
	logic [1:0] own_addr;
	logic [7:0] low_half;
	logic [7:0] trig_total;
	logic ctr_nib_on;
	logic [15:0] msg_word;
	logic [7:0] msg_data;
	logic [3:0] msg_crc;
	logic [15:0] cur_word;
	logic [3:0] status_nib;
	logic [3:0] crc_acc;
	logic [6:0] seg_len;
	logic [2:0] seg_next;
	logic [31:0] wval;
	logic hit;
	logic [1:0] hit_addr;

	always_comb begin
		next_r = r;
		own_addr = r.ctrl[SPC_C_ADDR +: 2];
		half_cyc = 9'((SPC_UT_MIN_NS + int'(r.ctrl[SPC_C_UT +: 2]) * SPC_UT_STEP_NS)
			/ (2 * SPC_CLK_NS));
		tick = (r.half_cnt == half_cyc - 9'h001);
		line_s = r.sync[1];
		fall = r.line_q & ~line_s;
		rise = ~r.line_q & line_s;
		low_half = 8'(2 * (r.ctrl[SPC_C_LOW5] ? SPC_LOW_LONG_UT : SPC_LOW_SHORT_UT));
		ctr_nib_on = r.ctrl[SPC_C_CTR_NIB] & ~r.ctrl[SPC_C_CTR_CRC];

		// Fixed counts, never the measured low time
		if (r.ctrl[SPC_C_VARTRIG]) begin
			trig_total = SPC_WIN_HI[r.addr_hit] + 8'(2 * SPC_TRIG_VAR_ADD_UT);
		end else begin
			trig_total = 8'(2 * SPC_TRIG_CONST_UT);
		end

		// Address window match on the measured low time
		hit = 1'b0;
		hit_addr = 2'h0;
		for (int a = 0; a < 4; a++) begin
			if (r.tcnt >= SPC_WIN_LO[a] && r.tcnt <= SPC_WIN_HI[a]) begin
				hit = 1'b1;
				hit_addr = 2'(a);
			end
		end

		// Slow message word for the current message id
		unique case (r.slow_id[2:0])
			3'h0, 3'h3: msg_data = r.temp;
			3'h1: msg_data = r.base[15:8];
			3'h2: msg_data = r.base[7:0];
			3'h4: msg_data = r.id1[15:8];
			3'h5: msg_data = r.id1[7:0];
			3'h6: msg_data = r.id2[15:8];
			3'h7: msg_data = r.id2[7:0];
		endcase
		msg_crc = spc_crc_step(spc_crc_step(spc_crc_step(SPC_CRC_SEED, r.slow_id),
			msg_data[7:4]), msg_data[3:0]);
		msg_word = {r.slow_id, msg_data, msg_crc};
		cur_word = (r.slow_idx == 4'h0) ? msg_word : r.slow_word;

		// Status nibble; errors held while present and until shown once
		status_nib[3] = r.err_pend | r.fault[SPC_F_ERR];
		status_nib[2] = r.warn_pend | r.fault[SPC_F_WARN];
		if (r.ctrl[SPC_C_SLOW]) begin
			status_nib[1] = (r.slow_idx == 4'h0);
			status_nib[0] = cur_word[4'hF - r.slow_idx];
		end else begin
			status_nib[1:0] = own_addr;
		end

		// Frame checksum input layout
		crc_acc = spc_crc_step(SPC_CRC_SEED, status_nib);
		crc_acc = spc_crc_step(crc_acc, r.angle[11:8]);
		crc_acc = spc_crc_step(crc_acc, r.angle[7:4]);
		crc_acc = spc_crc_step(crc_acc, r.angle[3:0]);
		if (ctr_nib_on) begin
			crc_acc = spc_crc_step(crc_acc, r.frame_ctr);
		end
		if (r.ctrl[SPC_C_CTR_CRC]) begin
			crc_acc = spc_crc_step(crc_acc, {r.frame_ctr[1:0],
				r.ctrl[SPC_C_SLOW] ? own_addr : 2'h0});
		end else if (r.ctrl[SPC_C_SLOW]) begin
			crc_acc = spc_crc_step(crc_acc, {2'h0, own_addr});
		end

		// Segment length in half unit times
		unique case (r.seg)
			SPC_SEG_SYNC: seg_len = 7'(2 * SPC_SYNC_UT);
			SPC_SEG_END: seg_len = 7'(2 * SPC_END_UT);
			default: seg_len = 7'(2 * (SPC_NIB_BASE_UT + int'(r.nib[r.seg - 3'h1])));
		endcase
		if (r.seg == SPC_SEG_D3 && !ctr_nib_on) begin
			seg_next = SPC_SEG_CRC;
		end else begin
			seg_next = r.seg + 3'h1;
		end

		// Synchroniser and tick divider
		next_r.sync = {r.sync[0], line_in};
		next_r.line_q = line_s;
		next_r.half_cnt = tick ? 9'h000 : r.half_cnt + 9'h001;
		next_r.warn_pend = r.warn_pend | r.fault[SPC_F_WARN];
		next_r.err_pend = r.err_pend | r.fault[SPC_F_ERR];

		// ==================== Link FSM ====================
		unique case (r.st)
			SPC_IDLE: begin
				next_r.drive = 1'b0;
				if (fall && r.ctrl[SPC_C_EN]) begin
					next_r.st = SPC_TRIG_LOW;
					next_r.tcnt = 8'h00;
					next_r.half_cnt = 9'h000;
				end
			end
			SPC_TRIG_LOW: begin
				if (tick) begin
					next_r.tcnt = r.tcnt + 8'h01;
				end
				if (rise) begin
					if (hit && hit_addr == own_addr) begin
						next_r.st = SPC_TRIG_WAIT;
						next_r.addr_hit = hit_addr;
					end else begin
						next_r.st = SPC_IDLE;
					end
				end else if (r.tcnt > SPC_WIN_MAX) begin
					next_r.st = SPC_IDLE;
				end
			end
			SPC_TRIG_WAIT: begin
				if (tick) begin
					next_r.tcnt = r.tcnt + 8'h01;
				end
				if (tick && r.tcnt == trig_total - 8'h01) begin
					// Sync fall closes the trigger nibble; snapshot the frame
					next_r.st = SPC_SEND;
					next_r.seg = SPC_SEG_SYNC;
					next_r.seg_t = 7'h00;
					next_r.drive = 1'b1;
					next_r.nib = {crc_acc, r.frame_ctr, r.angle[3:0], r.angle[7:4],
						r.angle[11:8], status_nib};
					next_r.slow_word = cur_word;
				end
			end
			SPC_SEND: begin
				if (tick) begin
					if (r.seg_t == seg_len - 7'h01) begin
						next_r.seg_t = 7'h00;
						if (r.seg == SPC_SEG_END) begin
							// Ready for a new trigger right at the end of the end pulse
							next_r.st = SPC_IDLE;
							next_r.drive = 1'b0;
							next_r.frame_ctr = r.frame_ctr + 4'h1;
							if (r.ctrl[SPC_C_SLOW]) begin
								next_r.slow_idx = r.slow_idx + 4'h1;
								if (r.slow_idx == 4'hF) begin
									next_r.slow_id = r.slow_id + 4'h1;
								end
							end
							// Clear only what was shown; a live fault sets again
							next_r.err_pend = (r.err_pend & ~r.nib[0][3]) | r.fault[SPC_F_ERR];
							next_r.warn_pend = (r.warn_pend & ~r.nib[0][2])
								| r.fault[SPC_F_WARN];
						end else begin
							next_r.seg = (r.seg == SPC_SEG_SYNC) ? 3'h1 : seg_next;
							next_r.drive = 1'b1;
						end
					end else begin
						next_r.seg_t = r.seg_t + 7'h01;
						next_r.drive = (r.seg_t + 7'h01) < 7'(low_half);
					end
				end
			end
		endcase

		// ==================== Register bus ====================
		next_r.ack = (avs_read | avs_write) & ~r.ack;
		wval = 32'h0000_0000;
		unique case (avs_address[4:2])
			SPC_REG_CTRL: wval = 32'(r.ctrl);
			SPC_REG_ANGLE: wval = 32'(r.angle);
			SPC_REG_FAULT: wval = 32'(r.fault);
			SPC_REG_TEMP: wval = 32'(r.temp);
			SPC_REG_BASE: wval = 32'(r.base);
			SPC_REG_ID1: wval = 32'(r.id1);
			SPC_REG_ID2: wval = 32'(r.id2);
			SPC_REG_STATUS: wval = {16'h0000, r.slow_id, r.slow_idx, r.err_pend,
				r.warn_pend, r.st != SPC_IDLE, 1'b0, r.frame_ctr};
		endcase
		if (avs_read && !r.ack) begin
			next_r.rdata = wval;
		end
		if (avs_write && r.ack) begin
			wval = spc_merge(wval, avs_writedata, avs_byteenable);
			unique case (avs_address[4:2])
				SPC_REG_CTRL: next_r.ctrl = wval[9:0];
				SPC_REG_ANGLE: next_r.angle = wval[11:0];
				SPC_REG_FAULT: next_r.fault = wval[1:0];
				SPC_REG_TEMP: next_r.temp = wval[7:0];
				SPC_REG_BASE: next_r.base = wval[15:0];
				SPC_REG_ID1: next_r.id1 = wval[15:0];
				SPC_REG_ID2: next_r.id2 = wval[15:0];
				SPC_REG_STATUS: ;
			endcase
			// Slow channel restarts a message when toggled
			if (avs_address[4:2] == SPC_REG_CTRL && wval[SPC_C_SLOW] != r.ctrl[SPC_C_SLOW]) begin
				next_r.slow_idx = 4'h0;
			end
		end
	end

	// ==================== Registers ====================
	always_ff @(posedge core_clk or posedge rst) begin
		if (rst) begin
			r <= '0;
			r.st <= SPC_IDLE;
			r.sync <= 2'b11;
			r.line_q <= 1'b1;
			r.ctrl <= SPC_CTRL_RST;
			// Sensor reset is reported in the first frame
			r.err_pend <= 1'b1;
		end else begin
			r <= next_r;
		end
	end

	assign avs_waitrequest = (avs_read | avs_write) & ~r.ack;
	assign avs_readdata = r.rdata;
	assign line_out = 1'b0;
	assign line_oe = r.drive;
endmodule

// ===== spc_triggered_frame_transmitter_sva.sv
`timescale 1ns/100ps
module spc_tft_sva (
	// Clock and reset
	input wire logic core_clk,
	input wire logic rst,
	// Bus
	input wire logic avs_read,
	input wire logic avs_write,
	input wire logic [31:0] avs_readdata,
	input wire logic avs_waitrequest,
	// Line
	input wire logic line_out,
	input wire logic line_oe
);
	import spc_pkg::*;
	// ==================== Helpers ====================
	// Figures assume UT select 0
	localparam int H = SPC_UT_MIN_NS / (2 * SPC_CLK_NS);
	int hi_cnt;
	int gap;
	always_ff @(posedge core_clk or posedge rst) begin
		if (rst) begin
			hi_cnt <= 0;
			gap <= 200 * H;
		end else begin
			hi_cnt <= line_oe ? hi_cnt + 1 : 0;
			if (line_oe && hi_cnt == 0) begin
				gap <= 1;
			end else if (gap < 200 * H) begin
				gap <= gap + 1;
			end
		end
	end
	// ==================== Properties ====================
	default clocking cb @(posedge core_clk); endclocking
	default disable iff (rst);
	line_pull_only_a: assert property (line_out == 1'b0)
		else $error("line driven high");
	wait_first_a: assert property ($rose(avs_read || avs_write) |-> avs_waitrequest)
		else $error("no wait state");
	wait_bound_a: assert property ((avs_read || avs_write) |-> ##[0:1] !avs_waitrequest)
		else $error("bus answer late");
	idle_nowait_a: assert property (!(avs_read || avs_write) |-> !avs_waitrequest)
		else $error("wait without request");
	rdata_hold_a: assert property (!avs_read |=> $stable(avs_readdata))
		else $error("read data changed");
	reset_quiet_a: assert property ($fell(rst) |-> !line_oe && avs_readdata == 32'h0)
		else $error("not quiet after reset");
	low_len_a: assert property ($fell(line_oe) |->
		hi_cnt == 6 * H || hi_cnt == 10 * H) else $error("bad low time");
	edge_gap_a: assert property ($rose(line_oe) && gap <= 112 * H |->
		gap == 112 * H || (gap >= 24 * H && gap <= 54 * H && gap % (2 * H) == 0))
		else $error("bad edge spacing");
	cover property ($fell(line_oe));
	cover property (avs_write && !avs_waitrequest);
	cover property (avs_read && !avs_waitrequest);
endmodule

bind spc_triggered_frame_transmitter spc_tft_sva spc_tft_sva_i (.core_clk(core_clk), .rst(rst),
	.avs_read(avs_read), .avs_write(avs_write), .avs_readdata(avs_readdata),
	.avs_waitrequest(avs_waitrequest), .line_out(line_out), .line_oe(line_oe));

// ===== spc_triggered_frame_transmitter_tb_top.sv
`timescale 1ns/100ps
module spc_triggered_frame_transmitter_tb_top;
	import spc_pkg::*;
	localparam int H = SPC_UT_MIN_NS / (2 * SPC_CLK_NS);
	logic core_clk;
	logic rst;
	logic [4:0] avs_address;
	logic avs_read;
	logic avs_write;
	logic [31:0] avs_writedata;
	logic [3:0] avs_byteenable;
	logic [31:0] avs_readdata;
	logic avs_waitrequest;
	logic line_in;
	logic line_out;
	logic line_oe;
	int failures;
	int compares;
	logic [31:0] rd;
	logic [11:0] angle;
	logic [7:0] temp;
	int nib[$];
	int t0;

	spc_triggered_frame_transmitter spc_triggered_frame_transmitter_i (.core_clk(core_clk),
		.rst(rst), .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
		.avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
		.avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest), .line_in(line_in),
		.line_out(line_out), .line_oe(line_oe));
	spc_master_model spc_master_model_i (.core_clk(core_clk), .line_oe(line_oe),
		.line_in(line_in));

	initial begin
		core_clk = 1'b0;
		forever #2 core_clk = !core_clk;
	end

	// ==================== Tasks ====================
	task automatic stop_test();
		$display("compares %0d failures %0d", compares, failures);
		if (failures == 0 && compares > 0) begin
			$display("bench passed");
		end else begin
			$display("bench failed");
		end
		$finish;
	endtask

	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		compares++;
		if (seen !== exp) begin
			failures++;
			$display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask

	// One edge passes before each request so strobes never toggle twice in a step
	task automatic bus(input logic wr, input logic [4:0] a, input logic [31:0] wd,
		input logic [3:0] be);
		int n;
		@(posedge core_clk);
		avs_address <= a;
		avs_read <= !wr;
		avs_write <= wr;
		avs_writedata <= wd;
		avs_byteenable <= be;
		n = 0;
		do begin
			@(posedge core_clk);
			n++;
		end while (avs_waitrequest !== 1'b0 && n < 20);
		rd = avs_readdata;
		avs_read <= 1'b0;
		avs_write <= 1'b0;
		if (avs_waitrequest !== 1'b0) begin
			failures++;
			stop_test();
		end
	endtask

	task automatic reg_chk(input logic [4:0] a, input logic [31:0] exp);
		bus(1'b0, a, 32'h0, 4'hF);
		chk(rd, exp);
	endtask

	function automatic logic [3:0] crc4(input int q[$]);
		logic [3:0] c;
		c = SPC_CRC_SEED;
		foreach (q[i]) begin
			c = c ^ 4'(q[i]);
			repeat (4) c = c[3] ? ({c[2:0], 1'b0} ^ SPC_CRC_POLY) : {c[2:0], 1'b0};
		end
		return c;
	endfunction

	// ==================== Sequence ====================
	initial begin
		rst = 1'b1;
		avs_address = 5'h0;
		avs_read = 1'b0;
		avs_write = 1'b0;
		avs_writedata = 32'h0;
		avs_byteenable = 4'h0;
		failures = 0;
		compares = 0;
		void'($urandom(32'h10A191E9));
		repeat (5) @(posedge core_clk);
		rst <= 1'b0;
		for (int i = 0; i < 8; i++) begin
			reg_chk(5'(i * 4), i == 0 ? 32'h8 : (i == 7 ? 32'h80 : 32'h0));
		end
		bus(1'b1, {SPC_REG_STATUS, 2'b00}, 32'hFFFF, 4'hF);
		reg_chk({SPC_REG_STATUS, 2'b00}, 32'h80);
		// Nibbles kept small so one frame fits the run
		angle = 12'($urandom) & 12'h777;
		temp = 8'($urandom);
		bus(1'b1, {SPC_REG_ANGLE, 2'b00}, {20'h0, angle}, 4'hF);
		bus(1'b1, {SPC_REG_TEMP, 2'b00}, {24'h0, temp}, 4'h1);
		bus(1'b1, {SPC_REG_TEMP, 2'b00}, {24'h0, ~temp}, 4'h0);
		reg_chk({SPC_REG_ANGLE, 2'b00}, {20'h0, angle});
		reg_chk({SPC_REG_TEMP, 2'b00}, {24'h0, temp});
		// Enabled, variable trigger, counter folded into checksum, address 0
		bus(1'b1, 5'h0, 32'h13, 4'hF);
		reg_chk(5'h0, 32'h13);
		spc_master_model_i.trigger(0, 10 * H);
		repeat (40 * H) @(posedge core_clk);
		chk(spc_master_model_i.falls.size(), 1);
		spc_master_model_i.falls.delete();
		// Low time in the address 1 window, own address 0: no wait state entered
		spc_master_model_i.trigger(0, 42 * H);
		repeat (4) @(posedge core_clk);
		bus(1'b0, {SPC_REG_STATUS, 2'b00}, 32'h0, 4'hF);
		chk(rd & 32'h20, 32'h0);
		spc_master_model_i.falls.delete();
		spc_master_model_i.trigger(12 * H, 21 * H);
		for (int n = 0; n < 600 * H && spc_master_model_i.falls.size() < 8; n++) begin
			@(posedge core_clk);
		end
		chk(spc_master_model_i.falls.size(), 8);
		if (spc_master_model_i.falls.size() != 8) begin
			stop_test();
		end
		t0 = spc_master_model_i.falls[1] - spc_master_model_i.falls[0];
		chk(t0 >= 48 * H - 4 && t0 <= 48 * H + 4, 1);
		chk(spc_master_model_i.falls[2] - spc_master_model_i.falls[1], 112 * H);
		// Error flag set after reset, address in low status bits, counter 0
		nib = {8, angle[11:8], angle[7:4], angle[3:0], 0};
		nib[4] = crc4(nib);
		for (int i = 0; i < 5; i++) begin
			t0 = spc_master_model_i.falls[i + 3] - spc_master_model_i.falls[i + 2];
			chk(t0, 2 * H * (12 + nib[i]));
		end
		repeat (30 * H) @(posedge core_clk);
		chk(spc_master_model_i.falls.size(), 8);
		chk({31'h0, line_oe}, 32'h0);
		bus(1'b0, {SPC_REG_STATUS, 2'b00}, 32'h0, 4'hF);
		chk(rd & 32'hFF, 32'h1);
		stop_test();
	end
endmodule
